// file: touch_cfg.svh
// constants for the touch button output logic
`ifndef TOUCH_CFG_SVH
`define TOUCH_CFG_SVH
`define CLK_HZ            25000000
`define PULSE_MS          5
`define DIAG_NORMAL_MS    350
`define DIAG_HIGH_MS      1000
`define HOLD_STEP_MS      20
`define PULSE_CYC         ((`CLK_HZ / 1000) * `PULSE_MS)
`define DIAG_NORMAL_CYC   ((`CLK_HZ / 1000) * `DIAG_NORMAL_MS)
`define DIAG_HIGH_CYC     ((`CLK_HZ / 1000) * `DIAG_HIGH_MS)
`define HOLD_STEP_CYC     ((`CLK_HZ / 1000) * `HOLD_STEP_MS)
`define CHANNELS          10
`define DEBOUNCE_W        4
`define HOLD_W            8
`define OUT_OFF           1'b1
`define OUT_ON            1'b0
`endif

// file: touch_pkg.sv
// types shared by the touch button output logic
package touch_pkg;
  typedef enum logic [1:0] {
    DIAG_WAIT  = 2'b00,
    DIAG_PULSE = 2'b01,
    DIAG_DONE  = 2'b10
  } diag_state_t;
  typedef logic [9:0] chan_vec_t;
endpackage : touch_pkg

// file: chan_if.sv
// per channel state carried between the top and the channel slice
`timescale 1ns/1ns
interface chan_if;
  logic touchRaw;
  logic scanTick;
  logic chanEnable;
  logic toggleEn;
  logic [3:0] debounceCnt;
  logic pressed;
  logic rise;
  modport top (output touchRaw, output scanTick, output chanEnable, output toggleEn, output debounceCnt,
               input pressed, input rise);
  modport chan (input touchRaw, input scanTick, input chanEnable, input toggleEn, input debounceCnt,
                output pressed, output rise);
endinterface : chan_if

// file: touch_debounce.sv
// debounce slice for one touch input channel
`timescale 1ns/1ns
`include "touch_cfg.svh"
module touch_debounce (
  input wire logic core_clk,
  input wire logic rst,
  chan_if.chan     ch
);
  logic [`DEBOUNCE_W-1:0] cnt_ff;
  logic                   pressed_ff;
  logic                   rise_ff;

  assign ch.pressed = pressed_ff;
  assign ch.rise    = rise_ff;

  // consecutive scan count while touched
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (!ch.chanEnable || !ch.touchRaw) begin
      cnt_ff <= '0; // grounded channel never counts
    end else if (ch.scanTick && cnt_ff != ch.debounceCnt) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // reported state and new touch pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pressed_ff <= 1'b0;
      rise_ff    <= 1'b0;
    end else begin
      rise_ff <= 1'b0;
      if (!ch.chanEnable || !ch.touchRaw) begin
        pressed_ff <= 1'b0;
      end else if (ch.scanTick && !pressed_ff && (cnt_ff + 1'b1 >= ch.debounceCnt || ch.debounceCnt == '0)) begin
        pressed_ff <= 1'b1; // on after the set number of scans
        rise_ff    <= 1'b1;
      end
    end
  end
endmodule : touch_debounce

// file: touch_button_output_logic.sv
// output side of the ten channel touch button controller
// Operation
// - ten touch input channels, each with its own button output pin
// - grounded touch input is a disabled channel and reports no touch
// - each button output follows its channel touch state without host
// - button outputs are active low: low when on, high when off
// - failed self test gives one 5 ms pulse after 350 or 1000 ms
// - with toggle, each new touch inverts the output, held after release
// - toggle is enabled per channel
// - host driven outputs take levels only from host writes
// - attention line flags button status changes to the host
// - every touch latched in status until the host reads it
// - audio driver output active on touch when buzzer enabled
// - touch must persist for a set number of scans before on
// - release hold time not applied to toggle channels
// - active high reset clears the whole block
// - each audio pin is buzzer driver or host output by setting
`timescale 1ns/1ns
`include "touch_cfg.svh"
module touch_button_output_logic #(
  parameter int CHANNELS        = `CHANNELS,
  parameter int DIAG_NORMAL_CYC = `DIAG_NORMAL_CYC,
  parameter int DIAG_HIGH_CYC   = `DIAG_HIGH_CYC,
  parameter int PULSE_CYC       = `PULSE_CYC,
  parameter int HOLD_STEP_CYC   = `HOLD_STEP_CYC,
  parameter int SCAN_CYC        = 250,
  parameter int BUZZ_DIV        = 6250
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire touch_pkg::chan_vec_t touchInputChannel,
  input  wire touch_pkg::chan_vec_t channelEnable,
  input  wire touch_pkg::chan_vec_t toggleEnable,
  input  wire touch_pkg::chan_vec_t diagFail,
  input  wire logic                highNoiseImmunity,
  input  wire logic [3:0]          debounceCount,
  input  wire logic [7:0]          releaseHoldTime,
  input  wire logic                buzzerEnable,
  input  wire logic [1:0]          audioPinIsHost,
  input  wire logic [1:0]          hostAudioLevel,
  input  wire logic                hostWrite0,
  input  wire logic                hostWrite1,
  input  wire logic                hostWriteLevel,
  input  wire logic                statusRead,
  output touch_pkg::chan_vec_t     buttonOutputPin,
  output touch_pkg::chan_vec_t     latchedStatus,
  output touch_pkg::chan_vec_t     buttonState,
  output logic                     hostDrivenOutput0,
  output logic                     hostDrivenOutput1,
  output logic                     audioDriverOut0,
  output logic                     audioDriverOut1,
  output logic                     attentionOut
);
  import touch_pkg::*;

  diag_state_t  diagState_ff;
  logic [31:0]  diagCnt_ff;
  logic [31:0]  scanCnt_ff;
  logic         scanTick_ff;
  logic [31:0]  holdCnt_ff;
  logic [7:0]   holdSteps_ff;
  logic [3:0]   holdChan_ff;
  logic         holdActive_ff;
  logic [31:0]  buzzCnt_ff;
  logic         buzzPhase_ff;
  chan_vec_t    toggle_ff;
  chan_vec_t    pressed;
  chan_vec_t    rise;
  chan_vec_t    prevPressed_ff;
  chan_vec_t    btnOut_ff;
  chan_vec_t    status_ff;
  chan_vec_t    state_ff;
  logic         attn_ff;
  logic         host0_ff;
  logic         host1_ff;
  logic         aud0_ff;
  logic         aud1_ff;
  logic         diagPulse;
  logic         anyPressed;
  chan_vec_t    falls;
  chan_vec_t    onLevel;
  logic [3:0]   holdPick;
  logic         holdStart;

  // one debounce slice per channel
  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
      chan_if cif ();
      assign cif.touchRaw    = touchInputChannel[i];
      assign cif.scanTick    = scanTick_ff;
      assign cif.chanEnable  = channelEnable[i] && diagState_ff == DIAG_DONE;
      assign cif.toggleEn    = toggleEnable[i];
      assign cif.debounceCnt = debounceCount;
      assign pressed[i]      = cif.pressed;
      assign rise[i]         = cif.rise;
      touch_debounce u_deb (
        .core_clk (core_clk),
        .rst      (rst),
        .ch       (cif)
      );
    end
  endgenerate

  // shared combinational terms
  assign diagPulse  = diagState_ff == DIAG_PULSE;
  assign anyPressed = |pressed;
  assign falls      = prevPressed_ff & ~pressed & ~toggleEnable;
  assign holdStart  = |falls && releaseHoldTime != '0;

  // newest release picked for the hold, highest channel on a tie
  always_comb begin
    holdPick = '0;
    for (int k = 0; k < CHANNELS; k++) begin
      if (falls[k]) begin
        holdPick = 4'(k);
      end
    end
  end

  // scan rate enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scanCnt_ff  <= '0;
      scanTick_ff <= 1'b0;
    end else begin
      scanTick_ff <= scanCnt_ff == 32'(SCAN_CYC - 1);
      scanCnt_ff  <= (scanCnt_ff == 32'(SCAN_CYC - 1)) ? '0 : scanCnt_ff + 1'b1;
    end
  end

  // power-up diagnostic timing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      diagState_ff <= DIAG_WAIT;
      diagCnt_ff   <= '0;
    end else begin
      unique case (diagState_ff)
        DIAG_WAIT: begin
          if (diagCnt_ff == 32'((highNoiseImmunity ? DIAG_HIGH_CYC : DIAG_NORMAL_CYC) - 1)) begin
            diagState_ff <= DIAG_PULSE; // start after 350 or 1000 ms
            diagCnt_ff   <= '0;
          end else begin
            diagCnt_ff <= diagCnt_ff + 1'b1;
          end
        end
        DIAG_PULSE: begin
          if (diagCnt_ff == 32'(PULSE_CYC - 1)) begin
            diagState_ff <= DIAG_DONE; // one 5 ms pulse
            diagCnt_ff   <= '0;
          end else begin
            diagCnt_ff <= diagCnt_ff + 1'b1;
          end
        end
        DIAG_DONE: diagCnt_ff <= '0;
        default:   diagState_ff <= DIAG_WAIT;
      endcase
    end
  end

  // toggle state per channel
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      toggle_ff <= '0; // all off after reset
    end else begin
      toggle_ff <= toggle_ff ^ (rise & toggleEnable);
    end
  end

  // release hold for the last released non toggle button
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prevPressed_ff <= '0;
      holdActive_ff  <= 1'b0;
      holdChan_ff    <= '0;
      holdSteps_ff   <= '0;
      holdCnt_ff     <= '0;
    end else begin
      prevPressed_ff <= pressed;
      if (holdStart) begin
        holdActive_ff <= 1'b1; // toggle channels excluded
        holdSteps_ff  <= releaseHoldTime;
        holdCnt_ff    <= '0;
        holdChan_ff   <= holdPick;
      end else if (|falls) begin
        holdActive_ff <= 1'b0;
      end else if (holdActive_ff) begin
        if (holdCnt_ff == 32'(HOLD_STEP_CYC - 1)) begin
          holdCnt_ff   <= '0;
          holdSteps_ff <= holdSteps_ff - 1'b1;
          if (holdSteps_ff == 8'h01) begin
            holdActive_ff <= 1'b0;
          end
        end else begin
          holdCnt_ff <= holdCnt_ff + 1'b1;
        end
      end
    end
  end

  // considered on level per channel; a fresh release bridges into the hold with no off gap
  always_comb begin
    for (int k = 0; k < CHANNELS; k++) begin
      if (!channelEnable[k]) begin
        onLevel[k] = 1'b0;
      end else if (toggleEnable[k]) begin
        onLevel[k] = toggle_ff[k];
      end else begin
        onLevel[k] = pressed[k] || (holdActive_ff && holdChan_ff == 4'(k))
                     || (holdStart && holdPick == 4'(k));
      end
    end
  end

  // button output pins, active low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      btnOut_ff <= {CHANNELS{`OUT_OFF}};
      state_ff  <= '0;
    end else begin
      state_ff  <= onLevel;
      for (int k = 0; k < CHANNELS; k++) begin
        if (diagPulse) begin
          btnOut_ff[k] <= diagFail[k] ? `OUT_ON : `OUT_OFF;
        end else if (!channelEnable[k]) begin
          btnOut_ff[k] <= `OUT_OFF;
        end else begin
          btnOut_ff[k] <= onLevel[k] ? `OUT_ON : `OUT_OFF;
        end
      end
    end
  end

  // latched touch status, set wins over read clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_ff <= '0;
    end else begin
      status_ff <= (statusRead ? '0 : status_ff) | rise;
    end
  end

  // attention on any status change
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      attn_ff <= 1'b0;
    end else begin
      attn_ff <= (attn_ff && !statusRead) || (onLevel != state_ff);
    end
  end

  // host driven outputs change only on host write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host0_ff <= 1'b0;
      host1_ff <= 1'b0;
    end else begin
      if (hostWrite0) begin
        host0_ff <= hostWriteLevel;
      end
      if (hostWrite1) begin
        host1_ff <= hostWriteLevel;
      end
    end
  end

  // buzzer tone divider
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buzzCnt_ff   <= '0;
      buzzPhase_ff <= 1'b0;
    end else if (buzzCnt_ff == 32'(BUZZ_DIV - 1)) begin
      buzzCnt_ff   <= '0;
      buzzPhase_ff <= ~buzzPhase_ff;
    end else begin
      buzzCnt_ff <= buzzCnt_ff + 1'b1;
    end
  end

  // audio pins, buzzer or host output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aud0_ff <= 1'b0;
      aud1_ff <= 1'b0;
    end else begin
      aud0_ff <= audioPinIsHost[0] ? hostAudioLevel[0]
                                   : (buzzerEnable && anyPressed && buzzPhase_ff);
      aud1_ff <= audioPinIsHost[1] ? hostAudioLevel[1]
                                   : (buzzerEnable && anyPressed && !buzzPhase_ff);
    end
  end

  // outputs straight from their registers
  assign buttonOutputPin   = btnOut_ff;
  assign latchedStatus     = status_ff;
  assign buttonState       = state_ff;
  assign hostDrivenOutput0 = host0_ff;
  assign hostDrivenOutput1 = host1_ff;
  assign audioDriverOut0   = aud0_ff;
  assign audioDriverOut1   = aud1_ff;
  assign attentionOut      = attn_ff;
endmodule : touch_button_output_logic

// file: touch_button_output_logic_monitor.sv
// assertion checker for the touch button output logic
`timescale 1ns/1ns
module touch_button_output_logic_monitor (
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire touch_pkg::chan_vec_t channelEnable,
  input wire touch_pkg::chan_vec_t toggleEnable,
  input wire logic                 buzzerEnable,
  input wire logic [1:0]           audioPinIsHost,
  input wire logic [1:0]           hostAudioLevel,
  input wire logic                 hostWrite0,
  input wire logic                 hostWriteLevel,
  input wire logic                 statusRead,
  input wire touch_pkg::chan_vec_t buttonOutputPin,
  input wire touch_pkg::chan_vec_t latchedStatus,
  input wire touch_pkg::chan_vec_t buttonState,
  input wire logic                 hostDrivenOutput0,
  input wire logic                 audioDriverOut0,
  input wire logic                 audioDriverOut1,
  input wire logic                 attentionOut
);
  import touch_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // a channel newly considered on
  sequence newTouch;
    (buttonState & ~$past(buttonState)) != 10'h000;
  endsequence
  reset_clears_a: assert property ($fell(rst) |-> buttonOutputPin == 10'h3FF && latchedStatus == 10'h000)
    else $error("outputs not cleared by reset");
  on_drives_low_a: assert property ((buttonState & ~toggleEnable & buttonOutputPin) == 10'h000)
    else $error("on channel output not low");
  disabled_quiet_a: assert property ((buttonState & ~channelEnable) == 10'h000)
    else $error("disabled channel reported on");
  touch_latched_a: assert property (newTouch |-> (buttonState & ~$past(buttonState) & ~latchedStatus) == 10'h000)
    else $error("touch not latched");
  read_clears_a: assert property (statusRead |=> (latchedStatus & ~(buttonState & ~$past(buttonState))) == 10'h000)
    else $error("status not cleared by read");
  attention_set_a: assert property (newTouch |-> attentionOut)
    else $error("attention not raised on touch");
  host_write_a: assert property (hostWrite0 |=> hostDrivenOutput0 == $past(hostWriteLevel))
    else $error("host output missed write");
  host_hold_a: assert property (!hostWrite0 |=> $stable(hostDrivenOutput0))
    else $error("host output changed without write");
  audio_host_a: assert property (audioPinIsHost == 2'b11 [*2] |-> {audioDriverOut1, audioDriverOut0} == $past(hostAudioLevel))
    else $error("audio pins not at host level");
  buzz_quiet_a: assert property ((!buzzerEnable && audioPinIsHost == 2'b00) [*3] |-> !audioDriverOut0 && !audioDriverOut1)
    else $error("buzzer active while disabled");
endmodule : touch_button_output_logic_monitor
bind touch_button_output_logic touch_button_output_logic_monitor mon_u (.*);

// file: touch_host_model.sv
// host and indicator model at the far side of the touch block
`timescale 1ns/1ns
module touch_host_model (
  input  wire logic core_clk,
  input  wire logic audioDriverOut0,
  output logic      hostWrite0,
  output logic      hostWrite1,
  output logic      hostWriteLevel,
  output logic      statusRead,
  output int        buzzEdges
);
  // idle strobes and a low write level
  initial begin
    hostWrite0 = 1'b0;
    hostWrite1 = 1'b0;
    hostWriteLevel = 1'b0;
    statusRead = 1'b0;
  end
  // buzzer edges heard
  always @(posedge audioDriverOut0) buzzEdges++;
  // host write strobe, held for one edge
  task automatic writeHost(input int idx, input logic lvl);
    @(negedge core_clk);
    hostWriteLevel = lvl;
    hostWrite0 = (idx == 0);
    hostWrite1 = (idx == 1);
    @(negedge core_clk);
    hostWrite0 = 1'b0;
    hostWrite1 = 1'b0;
  endtask : writeHost
  // host read after attention
  task automatic readStatus;
    @(negedge core_clk);
    statusRead = 1'b1;
    @(negedge core_clk);
    statusRead = 1'b0;
  endtask : readStatus
endmodule : touch_host_model

// file: touch_button_output_logic_test.sv
// self-checking bench for the touch button output logic
`timescale 1ns/1ns
module touch_button_output_logic_test;
  import touch_pkg::*;
  logic      core_clk = 1'b0;
  logic      rst = 1'b1;
  chan_vec_t touch = 10'h000;
  chan_vec_t chEn = 10'h1FF;
  chan_vec_t togEn = 10'h000;
  logic      noiseHi = 1'b0;
  logic [7:0] relHold = 8'h00;
  logic       buzzEn = 1'b1;
  logic [1:0] audHost = 2'b00;
  logic [1:0] audLvl = 2'b00;
  chan_vec_t  diagFl = 10'h004;
  logic [3:0] deb = 4'h3;
  logic       wr0, wr1, wrLvl, rd, hostOut0, hostOut1, audio0, audio1, attn;
  chan_vec_t  outPin, latched, state;
  int         buzzEdges, n, dly, e0;
  int         nFail = 0;
  int         nCompared = 0;
  always #20 core_clk = ~core_clk;
  touch_button_output_logic #(.DIAG_NORMAL_CYC(50), .DIAG_HIGH_CYC(100), .PULSE_CYC(5), .HOLD_STEP_CYC(4),
    .SCAN_CYC(2), .BUZZ_DIV(3)) dut_u (.core_clk(core_clk), .rst(rst), .touchInputChannel(touch),
    .channelEnable(chEn), .toggleEnable(togEn), .diagFail(diagFl), .highNoiseImmunity(noiseHi),
    .debounceCount(deb), .releaseHoldTime(relHold), .buzzerEnable(buzzEn), .audioPinIsHost(audHost),
    .hostAudioLevel(audLvl), .hostWrite0(wr0), .hostWrite1(wr1), .hostWriteLevel(wrLvl), .statusRead(rd),
    .buttonOutputPin(outPin), .latchedStatus(latched), .buttonState(state), .hostDrivenOutput0(hostOut0),
    .hostDrivenOutput1(hostOut1), .audioDriverOut0(audio0), .audioDriverOut1(audio1), .attentionOut(attn));
  touch_host_model host_u (.core_clk(core_clk), .audioDriverOut0(audio0), .hostWrite0(wr0), .hostWrite1(wr1),
    .hostWriteLevel(wrLvl), .statusRead(rd), .buzzEdges(buzzEdges));
  // verdict and end of run
  task automatic testDone;
    if (nFail == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : testDone
  // compare one value
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // wait for an output bit to reach a level, counting cycles
  task automatic waitFor(input int sel, input int k, input logic lvl, output int cnt);
    cnt = 0;
    while ((sel == 0 ? state[k] : sel == 1 ? outPin[k] : latched[k]) !== lvl) begin
      @(negedge core_clk);
      cnt++;
      if (cnt > 300) begin
        nFail++;
        testDone();
      end
    end
  endtask : waitFor
  // reset held for ten cycles
  task automatic resetRun(input logic hi);
    rst = 1'b1;
    noiseHi = hi;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
  endtask : resetRun
  // touch until latched, release, let debounce settle, clear status
  task automatic press(input int k);
    touch[k] = 1'b1;
    waitFor(2, k, 1'b1, n);
    touch[k] = 1'b0;
    repeat (12) @(negedge core_clk);
    host_u.readStatus();
  endtask : press
  initial begin
    for (int m = 0; m < 2; m++) begin
      diagFl = m ? 10'h204 : 10'h004;
      resetRun(m[0]);
      dly = m ? 100 : 50;
      waitFor(1, 2, 1'b0, n);
      chk(outPin, m ? 10'h1FB : 10'h3FB);
      chk(n >= dly - 1 && n <= dly + 2, 10'h1);
      waitFor(1, 2, 1'b1, n);
      chk(n, 10'd5);
    end
    e0 = buzzEdges;
    touch[0] = 1'b1;
    waitFor(0, 0, 1'b1, n);
    chk(n >= 4 && n <= 9, 10'h1);
    chk(outPin, 10'h3FE);
    chk(latched, 10'h001);
    chk(attn, 10'h1);
    repeat (12) @(negedge core_clk);
    chk(audio0 ^ audio1, 10'h1);
    chk(buzzEdges > e0, 10'h1);
    touch[0] = 1'b0;
    waitFor(0, 0, 1'b0, n);
    chk(outPin, 10'h3FF);
    chk(latched, 10'h001);
    host_u.readStatus();
    chk(attn, 10'h0);
    chk(latched, 10'h000);
    touch[9] = 1'b1;
    repeat (20) @(negedge core_clk);
    chk(latched | state, 10'h000);
    touch[9] = 1'b0;
    togEn = 10'h002;
    relHold = 8'h02;
    chEn = 10'h3FF;
    deb = 4'h1;
    press(1);
    chk(outPin, 10'h3FD);
    press(9);
    press(0);
    chk(outPin, 10'h3FD);
    press(1);
    chk(outPin, 10'h3FF);
    for (int i = 0; i < 4; i++) begin
      host_u.writeHost(i % 2, i < 2);
      chk({hostOut1, hostOut0}, {i == 1 || i == 2, i < 2});
    end
    buzzEn = 1'b0;
    audHost = 2'b11;
    for (int i = 1; i < 3; i++) begin
      audLvl = i[1:0];
      repeat (3) @(negedge core_clk);
      chk({audio1, audio0}, i[1:0]);
    end
    audHost = 2'b00;
    press(1);
    resetRun(1'b0);
    chk(outPin, 10'h3FF);
    repeat (70) @(negedge core_clk);
    chk(outPin, 10'h3FF);
    testDone();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    testDone();
  end
endmodule : touch_button_output_logic_test
